// ==== command_front_end.sv ====
`timescale 1ns/1ps
module command_front_end
   import lpc_flash_pkg::*;
#(
   parameter int PROG_COUNT  = PROG_CYCLES,
   parameter int ERASE_COUNT = ERASE_CYCLES
)(
   // Clock and reset
   input  wire logic          sys_clk,
   input  wire logic          rst,
   // Write requests
   input  wire logic          req_valid,
   input  wire flash_req_type req,
   // Sector decode
   input  wire logic [2:0]    sector,
   input  wire logic          blocked,
   // State
   output logic               uniform_q,
   output logic               show_status_q,
   output logic               busy_q,
   output logic [7:0]         status_q,
   output array_cmd_type      array_cmd_q
);

   typedef enum logic [2:0] {
      M_READ = 3'b000, M_STATUS = 3'b001, M_PROG = 3'b011, M_ERASE = 3'b010, M_BUSY = 3'b110
   } mode_type;

   mode_type         mode_q, mode_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic [7:0]       status_d;
   logic             uniform_d;
   array_cmd_type    cmd_d;

   always_comb begin
      mode_d    = mode_q;
      cnt_d     = cnt_q;
      status_d  = status_q;
      uniform_d = uniform_q;
      cmd_d     = '{op: ARR_IDLE, sector: sector, uniform: uniform_q,
                    addr: req.addr, data: req.data};
      case (mode_q)
         M_READ, M_STATUS: begin
            if (req_valid) begin
               case (req.data)
                  CMD_READ_ARRAY:  mode_d = M_READ;
                  CMD_READ_STATUS: mode_d = M_STATUS;
                  CMD_CLR_STATUS:  status_d = STATUS_RESET;
                  CMD_PROG: begin
                     mode_d    = M_PROG;
                     uniform_d = 1'b0;
                  end
                  CMD_ERASE: begin
                     mode_d    = M_ERASE;
                     uniform_d = 1'b0;                   // RULE5
                  end
                  CMD_ERASE_UNI: begin
                     mode_d    = M_ERASE;
                     uniform_d = 1'b1;                   // RULE6
                  end
                  default: mode_d = mode_q;
               endcase
            end
         end
         M_PROG: begin
            if (req_valid) begin
               if (blocked) begin
                  status_d[ST_PROG_ERR] = 1'b1;
                  status_d[ST_LOCKED]   = 1'b1;
                  mode_d                = M_STATUS;
               end else begin
                  cmd_d.op = ARR_PROG;                   // RULE13
                  cnt_d    = CNT_W'(PROG_COUNT - 1);     // RULE14
                  mode_d   = M_BUSY;
               end
            end
         end
         M_ERASE: begin
            if (req_valid) begin
               if (req.data != CMD_CONFIRM) begin
                  status_d[ST_ERASE_ERR] = 1'b1;
                  mode_d                 = M_STATUS;
               end else if (blocked) begin
                  status_d[ST_ERASE_ERR] = 1'b1;         // RULE8
                  status_d[ST_LOCKED]    = 1'b1;
                  mode_d                 = M_STATUS;
               end else begin
                  cmd_d.op = ARR_ERASE;                  // RULE13
                  cnt_d    = CNT_W'(ERASE_COUNT - 1);    // RULE14
                  mode_d   = M_BUSY;
               end
            end
         end
         M_BUSY: begin
            // Writes are ignored while the array operation runs
            if (cnt_q == '0) begin
               mode_d             = M_STATUS;
               status_d[ST_READY] = 1'b1;
            end else begin
               cnt_d = cnt_q - CNT_W'(1);
            end
         end
         default: mode_d = M_READ;
      endcase
      if (mode_d == M_BUSY)
         status_d[ST_READY] = 1'b0;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mode_q        <= M_READ;                        // RULE3 RULE4
         cnt_q         <= '0;
         status_q      <= STATUS_RESET;
         uniform_q     <= 1'b0;
         show_status_q <= 1'b0;
         busy_q        <= 1'b0;
         array_cmd_q   <= '0;
      end else begin
         mode_q        <= mode_d;
         cnt_q         <= cnt_d;
         status_q      <= status_d;
         uniform_q     <= uniform_d;
         show_status_q <= (mode_d != M_READ);
         busy_q        <= (mode_d == M_BUSY);
         array_cmd_q   <= cmd_d;
      end
   end

endmodule

// ==== flash_chk.sv ====
`timescale 1ns/1ps
module flash_chk
   import lpc_flash_pkg::*;
(
   // Pins
   input wire logic          sys_clk,
   input wire logic          rst,
   input wire logic          reset_pin_n,
   input wire logic          init_n,
   input wire logic          interface_select,
   input wire logic          hub_frame_in_n,
   // Outputs
   input wire logic [3:0]    lad_out,
   input wire logic          lad_oe,
   input wire array_cmd_type array_cmd,
   input wire logic          busy,
   input wire logic          mux_mode
);
   wire int_rst = rst | ~reset_pin_n | (~mux_mode & ~init_n);
   wire lpc_rise = lad_oe & ~mux_mode;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Drive two, release within three
   sequence s_turn;
      lad_oe ##1 lad_oe ##[1:3] !lad_oe;
   endsequence
   a_reset_floats_lad: assert property (!reset_pin_n |=>
      !lad_oe && !busy && array_cmd.op == ARR_IDLE) else $error("reset drive");
   a_init_resets_lpc: assert property (!mux_mode && !init_n |=>
      !lad_oe && !busy) else $error("init reset");
   a_select_sampled: assert property (!reset_pin_n |=>
      mux_mode == $past(interface_select)) else $error("select latch");
   a_select_held: assert property (!int_rst |=>
      mux_mode == $past(mux_mode)) else $error("select moved");
   a_sync_after_frame: assert property ($rose(lpc_rise) |-> lad_out == SYNC_READY &&
      (!$past(hub_frame_in_n, 12) || !$past(hub_frame_in_n, 14))) else $error("sync");
   a_turn_release: assert property ($rose(lpc_rise) |-> s_turn)
      else $error("turnaround");
   a_abort_quiet: assert property (!hub_frame_in_n && !mux_mode |=>
      !lad_oe [*8]) else $error("drive after frame");
   a_cmd_pulse: assert property (array_cmd.op != ARR_IDLE |=>
      array_cmd.op == ARR_IDLE && busy) else $error("start pulse");
   a_busy_fixed: assert property ($rose(busy) |-> busy [*6] ##[1:12] !busy)
      else $error("busy length");
endmodule
bind lpc_flash_interface_ctrl flash_chk chk_u (.sys_clk, .rst, .reset_pin_n, .init_n,
   .interface_select, .hub_frame_in_n, .lad_out, .lad_oe, .array_cmd, .busy, .mux_mode);

// ==== lpc_flash_interface_ctrl.sv ====
`timescale 1ns/1ps
module lpc_flash_interface_ctrl
   import lpc_flash_pkg::*;
#(
   parameter int PROG_COUNT  = PROG_CYCLES,
   parameter int ERASE_COUNT = ERASE_CYCLES
)(
   // Clock and system reset
   input  wire logic              sys_clk,
   input  wire logic              rst,
   // Reset and strap pins
   input  wire logic              reset_pin_n,
   input  wire logic              init_n,
   input  wire logic              interface_select,
   // Bus clock pin, used as row/column strobe in mux mode
   input  wire logic              clk_pin_row_col,
   // Frame pin, write strobe in mux mode
   input  wire logic              hub_frame_in_n,
   // Address/data lines 3..0
   input  wire logic [3:0]        lad_in,
   output logic [3:0]             lad_out,
   output logic                   lad_oe,
   // Programming port
   input  wire logic [MUX_ROW_W-1:0] mux_addr,
   input  wire logic [3:0]        mux_data_in,
   output logic [3:0]             mux_data_out,
   output logic                   mux_data_oe,
   // Hardware protect pins
   input  wire logic              top_boot_lock_n,
   input  wire logic              write_protect_n,
   // Array side
   input  wire logic [DATA_W-1:0] array_rdata,
   output logic [ADDR_W-1:0]      array_raddr,
   output array_cmd_type          array_cmd,
   output logic                   busy,
   output logic                   mux_mode
);

   // ---
   // Reset and interface choice
   // ---
   logic mux_mode_q;
   wire logic dev_rst;

   // In mux mode the initialize pin is the output enable instead
   assign dev_rst = rst | ~reset_pin_n | (~mux_mode_q & ~init_n);    // RULE3 RULE18

   // Strap is tracked while reset is held and frozen at release
   always_ff @(posedge sys_clk) begin
      if (dev_rst)
         mux_mode_q <= interface_select;                 // RULE1 RULE19 RULE2
   end

   // ---
   // Bus cycle decoder
   // ---
   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0000, ST_CYCTYPE = 4'b0001, ST_ADDR = 4'b0011, ST_WDATA = 4'b0010,
      ST_TAR1  = 4'b0110, ST_SYNC    = 4'b0111, ST_RDATA = 4'b0101, ST_TAR2 = 4'b0100,
      ST_IDSEL = 4'b1100, ST_MSIZE   = 4'b1101
   } lpc_state_type;

   lpc_state_type st_q, st_d;
   logic [2:0]  nib_q, nib_d;
   logic        hub_q, hub_d;
   logic        wr_q, wr_d;
   logic [31:0] addr_q, addr_d;
   logic [7:0]  wdata_q, wdata_d;
   logic [7:0]  rdata_q;
   logic [3:0]  lad_out_q, lad_d;
   logic        lad_oe_q, oe_d;
   logic        lpc_req, rd_grab;

   wire logic       frame_low;
   wire logic       start_ok;
   wire logic       addr_done;
   wire logic [7:0] rd_byte;
   wire logic       show_status;
   wire logic [7:0] status;

   assign frame_low = ~hub_frame_in_n & ~mux_mode_q;
   assign start_ok  = (lad_in == START_LPC) | (lad_in == START_HUB_RD) | (lad_in == START_HUB_WR);
   assign addr_done = nib_q == (hub_q ? HUB_ADDR_LAST : LPC_ADDR_LAST);
   assign rd_byte   = show_status ? status : array_rdata;

   always_comb begin
      st_d    = st_q;
      nib_d   = nib_q + 3'h1;
      hub_d   = hub_q;
      wr_d    = wr_q;
      addr_d  = addr_q;
      wdata_d = wdata_q;
      lad_d   = TAR_IDLE;
      oe_d    = 1'b0;
      lpc_req = 1'b0;
      rd_grab = 1'b0;
      if (frame_low) begin
         // Frame always restarts decode, abandoning any cycle underway
         nib_d = 3'h0;                                   // RULE10 RULE11
         hub_d = (lad_in != START_LPC);                  // RULE12
         wr_d  = (lad_in == START_HUB_WR);
         if (!start_ok)
            st_d = ST_IDLE;
         else if (lad_in == START_LPC)
            st_d = ST_CYCTYPE;
         else
            st_d = ST_IDSEL;
      end else begin
         case (st_q)
            ST_IDLE: nib_d = 3'h0;
            ST_CYCTYPE: begin
               nib_d = 3'h0;
               wr_d  = (lad_in == CYC_MEM_WR);
               if (lad_in == CYC_MEM_RD || lad_in == CYC_MEM_WR)
                  st_d = ST_ADDR;                        // RULE12
               else
                  st_d = ST_IDLE;
            end
            ST_IDSEL: begin
               nib_d = 3'h0;
               st_d  = (lad_in == HUB_ID) ? ST_ADDR : ST_IDLE;
            end
            ST_ADDR: begin
               addr_d = {addr_q[27:0], lad_in};
               if (addr_done) begin
                  nib_d = 3'h0;
                  if (hub_q)
                     st_d = ST_MSIZE;
                  else
                     st_d = wr_q ? ST_WDATA : ST_TAR1;
               end
            end
            ST_MSIZE: begin
               nib_d = 3'h0;
               if (lad_in != MSIZE_BYTE)
                  st_d = ST_IDLE;                        // RULE15
               else
                  st_d = wr_q ? ST_WDATA : ST_TAR1;
            end
            ST_WDATA: begin
               // Low nibble arrives first
               wdata_d = {lad_in, wdata_q[7:4]};
               if (nib_q[0]) begin
                  nib_d = 3'h0;
                  st_d  = ST_TAR1;
               end
            end
            ST_TAR1: begin
               if (nib_q[0]) begin
                  nib_d = 3'h0;
                  st_d  = ST_SYNC;
                  lad_d = SYNC_READY;
                  oe_d  = 1'b1;
               end
            end
            ST_SYNC: begin
               nib_d   = 3'h0;
               lpc_req = wr_q;
               rd_grab = ~wr_q;
               oe_d    = 1'b1;
               if (wr_q) begin
                  st_d = ST_TAR2;
               end else begin
                  st_d  = ST_RDATA;
                  lad_d = rd_byte[3:0];
               end
            end
            ST_RDATA: begin
               oe_d = 1'b1;
               if (!nib_q[0]) begin
                  lad_d = rdata_q[7:4];
               end else begin
                  nib_d = 3'h0;
                  st_d  = ST_TAR2;
               end
            end
            ST_TAR2: begin
               // Drive ones for one cycle, then hand the lines back
               nib_d = 3'h0;
               st_d  = ST_IDLE;
            end
            default: st_d = ST_IDLE;
         endcase
      end
   end

   // ---
   // Programming port
   // ---
   logic [MUX_ROW_W-1:0] row_q;
   logic [MUX_COL_W-1:0] col_q;
   logic                 rc_prev_q;
   logic                 we_prev_q;

   wire logic                 rc_fall;
   wire logic                 rc_rise;
   wire logic                 mux_req;
   wire logic                 mux_read;
   wire logic [ADDR_W-1:0]    mux_full_addr;
   wire logic [3:0]           lad_next;
   wire logic                 lad_oe_next;

   assign rc_fall       = rc_prev_q & ~clk_pin_row_col;
   assign rc_rise       = ~rc_prev_q & clk_pin_row_col;
   // Write taken on strobe rise; data must be stable
   assign mux_req       = mux_mode_q & ~we_prev_q & hub_frame_in_n;           // RULE16
   assign mux_read      = mux_mode_q & ~init_n & hub_frame_in_n;
   assign mux_full_addr = {col_q, row_q};
   assign lad_next      = mux_mode_q ? rd_byte[3:0] : lad_d;
   assign lad_oe_next   = mux_mode_q ? mux_read : oe_d;

   always_ff @(posedge sys_clk) begin
      if (dev_rst) begin
         row_q     <= '0;
         col_q     <= '0;
         rc_prev_q <= 1'b0;
         we_prev_q <= 1'b1;
      end else begin
         rc_prev_q <= clk_pin_row_col;
         we_prev_q <= hub_frame_in_n;
         if (rc_fall)
            row_q <= mux_addr;                           // RULE16
         if (rc_rise)
            col_q <= mux_addr[MUX_COL_W-1:0];
      end
   end

   // ---
   // Decoder registers and pin drivers
   // ---
   logic [3:0]        mux_data_out_q;
   logic              mux_data_oe_q;
   logic [ADDR_W-1:0] array_raddr_q;

   always_ff @(posedge sys_clk) begin
      if (dev_rst) begin
         st_q           <= ST_IDLE;
         nib_q          <= 3'h0;
         hub_q          <= 1'b0;
         wr_q           <= 1'b0;
         addr_q         <= '0;
         wdata_q        <= '0;
         rdata_q        <= '0;
         lad_out_q      <= TAR_IDLE;
         lad_oe_q       <= 1'b0;                         // RULE3
         mux_data_out_q <= '0;
         mux_data_oe_q  <= 1'b0;
         array_raddr_q  <= '0;
      end else begin
         st_q           <= mux_mode_q ? ST_IDLE : st_d;
         nib_q          <= nib_d;
         hub_q          <= hub_d;
         wr_q           <= wr_d;
         addr_q         <= addr_d;
         wdata_q        <= wdata_d;
         lad_out_q      <= lad_next;
         lad_oe_q       <= lad_oe_next;
         mux_data_out_q <= rd_byte[7:4];
         mux_data_oe_q  <= mux_read;
         array_raddr_q  <= mux_mode_q ? mux_full_addr : addr_d[ADDR_W-1:0];
         if (rd_grab)
            rdata_q <= rd_byte;
      end
   end

   // ---
   // Command path
   // ---
   flash_req_type   req;
   wire logic       req_valid;
   wire logic [2:0] sector;
   wire logic       blocked;
   wire logic       uniform;

   // Writes never reach the front end while reset is held
   assign req_valid = (lpc_req | mux_req) & ~dev_rst;                         // RULE3
   assign req.addr  = mux_mode_q ? mux_full_addr : addr_q[ADDR_W-1:0];
   assign req.data  = mux_mode_q ? {mux_data_in, lad_in} : wdata_q;

   sector_decode u_decode (
      .addr            (req.addr),
      .uniform         (uniform),
      .top_boot_lock_n (top_boot_lock_n),
      .write_protect_n (write_protect_n),
      .sector          (sector),
      .blocked         (blocked)
   );

   command_front_end #(
      .PROG_COUNT  (PROG_COUNT),
      .ERASE_COUNT (ERASE_COUNT)
   ) u_cfe (
      .sys_clk       (sys_clk),
      .rst           (dev_rst),
      .req_valid     (req_valid),
      .req           (req),
      .sector        (sector),
      .blocked       (blocked),
      .uniform_q     (uniform),
      .show_status_q (show_status),
      .busy_q        (busy),
      .status_q      (status),
      .array_cmd_q   (array_cmd)
   );

   assign lad_out      = lad_out_q;
   assign lad_oe       = lad_oe_q;
   assign mux_data_out = mux_data_out_q;
   assign mux_data_oe  = mux_data_oe_q;
   assign array_raddr  = array_raddr_q;
   assign mux_mode     = mux_mode_q;

endmodule

// ==== lpc_flash_pkg.sv ====
// Notes on behaviour
// RULE1: Select high picks mux port, low LPC.
// RULE2: System holds select steady while operating.
// RULE3: Reset blocks writes, resets automation, floats LAD.
// RULE4: Leaving reset enters read-array mode.
// RULE5: First erase command uses seven-sector layout.
// RULE6: Alternative erase uses four 64 KB sectors.
// RULE7: Boot lock protects top 16 KB sector.
// RULE8: Lock with uniform erase guards top 64K.
// RULE9: Write-protect guards all non-boot sectors.
// RULE10: Frame assertion starts decoding a new cycle.
// RULE11: Frame during a cycle abandons it.
// RULE12: Hub and LPC memory cycles auto-detected.
// RULE13: Automation starts only after valid command sequence.
// RULE14: Program and erase durations are fixed.
// RULE15: Five-signal byte port on bus clock.
// RULE16: Mux port: 11 address, 8 data, strobes.
// RULE17: Boot lock low rejects top program/erase.
// RULE18: Initialize input acts as second reset.
// RULE19: Select sampled at reset release, then held.
package lpc_flash_pkg;

   // ---
   // Widths
   // ---
   localparam int ADDR_W    = 18;
   localparam int DATA_W    = 8;
   localparam int MUX_ROW_W = 11;
   localparam int MUX_COL_W = 7;

   // ---
   // Bus cycle codes
   // ---
   localparam logic [3:0] START_LPC    = 4'h0;
   localparam logic [3:0] START_HUB_RD = 4'hd;
   localparam logic [3:0] START_HUB_WR = 4'he;
   localparam logic [3:0] CYC_MEM_RD   = 4'h4;
   localparam logic [3:0] CYC_MEM_WR   = 4'h6;
   localparam logic [3:0] HUB_ID       = 4'h0;
   localparam logic [3:0] MSIZE_BYTE   = 4'h0;
   localparam logic [3:0] SYNC_READY   = 4'h0;
   localparam logic [3:0] TAR_IDLE     = 4'hf;
   localparam logic [2:0] LPC_ADDR_LAST = 3'h7;
   localparam logic [2:0] HUB_ADDR_LAST = 3'h6;

   // ---
   // Sector map
   // ---
   localparam logic [ADDR_W-1:0] SEC6_BASE = 18'h3c000;
   localparam logic [ADDR_W-1:0] SEC5_BASE = 18'h3a000;
   localparam logic [ADDR_W-1:0] SEC4_BASE = 18'h38000;
   localparam logic [ADDR_W-1:0] SEC3_BASE = 18'h30000;
   localparam logic [2:0] TOP_BOOT_SEC = 3'h6;
   localparam logic [2:0] TOP_UNI_SEC  = 3'h3;

   // ---
   // Command front end codes and status bits
   // ---
   localparam logic [7:0] CMD_READ_ARRAY  = 8'hff;
   localparam logic [7:0] CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] CMD_CLR_STATUS  = 8'h50;
   localparam logic [7:0] CMD_PROG        = 8'h40;
   localparam logic [7:0] CMD_ERASE       = 8'h20;
   localparam logic [7:0] CMD_ERASE_UNI   = 8'h30;
   localparam logic [7:0] CMD_CONFIRM     = 8'hd0;
   localparam int ST_READY     = 7;
   localparam int ST_ERASE_ERR = 5;
   localparam int ST_PROG_ERR  = 4;
   localparam int ST_LOCKED    = 1;
   localparam logic [7:0] STATUS_RESET = 8'h80;

   // ---
   // Timing
   // ---
   localparam int CLK_MHZ       = 250;
   localparam int PROG_TIME_US  = 20;
   localparam int ERASE_TIME_US = 500000;
   localparam int PROG_CYCLES   = PROG_TIME_US * CLK_MHZ;
   localparam int ERASE_CYCLES  = ERASE_TIME_US * CLK_MHZ;
   localparam int CNT_W         = 32;

   // ---
   // Types
   // ---
   typedef enum logic [1:0] {ARR_IDLE = 2'h0, ARR_PROG = 2'h1, ARR_ERASE = 2'h2} array_op_type;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } flash_req_type;

   typedef struct packed {
      array_op_type      op;
      logic [2:0]        sector;
      logic              uniform;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } array_cmd_type;

endpackage

// ==== lpc_host.sv ====
`timescale 1ns/1ps
module lpc_host
   import lpc_flash_pkg::*;
(
   // Bus
   input  wire logic  sys_clk,
   output logic       hub_frame_in_n,
   output logic [3:0] lad_in
);
   initial begin
      hub_frame_in_n = 1'b1;
      lad_in = 4'hf;
   end
   // stop cuts the cycle short
   task automatic xfer(input logic hub, input logic wr, input logic [17:0] a,
                       input logic [7:0] d, input int stop);
      logic [3:0]  nib [16];
      logic [31:0] fa;
      int          n;
      fa = {14'h0, a};
      nib[0] = hub ? (wr ? START_HUB_WR : START_HUB_RD) : START_LPC;
      nib[1] = hub ? HUB_ID : (wr ? CYC_MEM_WR : CYC_MEM_RD);
      n = 2;
      for (int i = hub ? 6 : 7; i >= 0; i--) begin
         nib[n++] = fa[i*4 +: 4];
      end
      if (hub) begin
         nib[n++] = MSIZE_BYTE;
      end
      if (wr) begin
         nib[n++] = d[3:0];
         nib[n++] = d[7:4];
      end
      nib[n++] = TAR_IDLE;
      nib[n++] = TAR_IDLE;
      for (int k = 0; k < n && k < stop; k++) begin
         @(negedge sys_clk);
         hub_frame_in_n <= (k != 0);
         lad_in <= nib[k];
      end
      // Wait out the answer
      if (stop >= n) begin
         repeat (wr ? 4 : 6) @(negedge sys_clk);
      end
   endtask
endmodule

// ==== sector_decode.sv ====
`timescale 1ns/1ps
module sector_decode
   import lpc_flash_pkg::*;
(
   // Address and layout
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic              uniform,
   // Protect pins
   input  wire logic              top_boot_lock_n,
   input  wire logic              write_protect_n,
   // Result
   output logic [2:0]             sector,
   output logic                   blocked
);

   function automatic logic [2:0] sector_of(input logic [ADDR_W-1:0] a, input logic uni);
      if (uni)
         return {1'b0, a[17:16]};                        // RULE6
      else if (a >= SEC6_BASE)
         return 3'h6;                                    // RULE5
      else if (a >= SEC5_BASE)
         return 3'h5;
      else if (a >= SEC4_BASE)
         return 3'h4;
      else if (a >= SEC3_BASE)
         return 3'h3;
      else
         return {1'b0, a[17:16]};
   endfunction

   wire logic in_boot;

   assign sector  = sector_of(addr, uniform);
   assign in_boot = uniform ? (sector == TOP_UNI_SEC) : (sector == TOP_BOOT_SEC); // RULE8
   // RULE7 RULE17 RULE9
   assign blocked = in_boot ? ~top_boot_lock_n : ~write_protect_n;

endmodule

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
   import lpc_flash_pkg::*;
   logic          sys_clk, rst, reset_pin_n, init_n, interface_select, clk_pin_row_col;
   logic          top_boot_lock_n, write_protect_n, hub_frame_in_n, lad_oe, mux_data_oe;
   logic          busy, mux_mode;
   logic [3:0]    lad_in, lad_out, mux_data_out;
   logic [3:0]    mux_data_in = 4'h0;
   logic [10:0]   mux_addr;
   logic [17:0]   array_raddr, a;
   logic [7:0]    array_rdata;
   logic [8:0]    e, exp_q[$];
   array_cmd_type array_cmd, cmd_q[$];
   logic [31:0]   seed = 32'hcc4d;
   int            failures = 0, checks = 0, cyc = 0;
   logic [17:0]   base [7] = '{SEC6_BASE, SEC5_BASE, SEC4_BASE, SEC3_BASE, 18'h20000,
                               18'h10000, 18'h0};
   localparam array_cmd_type NONE = '0;
   function automatic logic [7:0] mem(input logic [17:0] x);
      return x[7:0] ^ {2'h0, x[17:12]};
   endfunction
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   assign array_rdata = mem(array_raddr);
   lpc_flash_interface_ctrl #(.PROG_COUNT(8), .ERASE_COUNT(16)) dut_u (.sys_clk, .rst,
      .reset_pin_n, .init_n, .interface_select, .clk_pin_row_col, .hub_frame_in_n, .lad_in,
      .lad_out, .lad_oe, .mux_addr, .mux_data_in, .mux_data_out, .mux_data_oe,
      .top_boot_lock_n, .write_protect_n, .array_rdata, .array_raddr, .array_cmd, .busy,
      .mux_mode);
   lpc_host host_u (.sys_clk, .hub_frame_in_n, .lad_in);
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   task automatic check4(input logic [3:0] g, input logic [3:0] x);
      checks++;
      if (g !== x) begin
         failures++;
         $display("MISMATCH %0t nibble %h expected %h", $time, g, x);
      end
   endtask
   task automatic check_cmd(input array_cmd_type g, input array_cmd_type x);
      checks++;
      if (g.op !== x.op || g.sector !== x.sector || (x.op == ARR_ERASE ?
          g.uniform !== x.uniform : {g.addr, g.data} !== {x.addr, x.data})) begin
         failures++;
         $display("MISMATCH %0t cmd", $time);
      end
   endtask
   task automatic wrap_up();
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic wr(input logic [17:0] x, input logic [7:0] d);
      exp_q.push_back(9'h0);
      host_u.xfer(1'b0, 1'b1, x, d, 99);
   endtask
   task automatic rd(input logic hub, input logic [17:0] x, input logic [7:0] d);
      exp_q.push_back({1'b1, d});
      host_u.xfer(hub, 1'b0, x, 8'h0, 99);
   endtask
   task automatic op(input logic [17:0] x, input logic [7:0] c1, input logic [7:0] c2,
                     input array_cmd_type c, input logic [7:0] st);
      if (c.op != ARR_IDLE)
         cmd_q.push_back(c);
      wr(x, c1);
      wr(x, c2);
      repeat (20) @(negedge sys_clk);
      rd(1'b0, x, st);
      wr(x, CMD_CLR_STATUS);
      wr(x, CMD_READ_ARRAY);
   endtask
   // ---
   // Watchers
   // ---
   always @(negedge sys_clk) begin
      if (array_cmd.op !== ARR_IDLE)
         check_cmd(array_cmd, cmd_q.size() ? cmd_q.pop_front() : NONE);
   end
   initial forever begin
      @(negedge sys_clk);
      if (lad_oe === 1'b1 && mux_mode === 1'b0) begin
         check4(lad_out, SYNC_READY);
         e = exp_q.size() ? exp_q.pop_front() : 9'h1a5;
         if (e[8]) begin
            @(negedge sys_clk) check4(lad_out, e[3:0]);
            @(negedge sys_clk) check4(lad_out, e[7:4]);
         end
         while (lad_oe === 1'b1) @(negedge sys_clk);
      end
   end
   always @(posedge sys_clk) begin
      if (++cyc == 30000) begin
         failures++;
         wrap_up();
      end
   end
   // ---
   // Main sequence
   // ---
   initial begin
      {rst, reset_pin_n, init_n, top_boot_lock_n, write_protect_n} = 5'h1f;
      {interface_select, clk_pin_row_col, mux_addr} = {1'b0, 1'b1, 11'h0};
      repeat (6) @(negedge sys_clk);
      rst = 1'b0;
      for (int i = 0; i < 4; i++) begin
         a = rnd();
         rd(i[0], a, mem(a));
      end
      host_u.xfer(1'b0, 1'b0, 18'h1234, 8'h0, 5);
      rd(1'b1, 18'h3ffff, mem(18'h3ffff));
      a = 18'h3c010;
      e = {1'b0, rnd()};
      op(a, CMD_PROG, e[7:0], '{ARR_PROG, 3'h6, 1'b0, a, e[7:0]}, 8'h80);
      for (int i = 0; i < 7; i++)
         op(base[i], CMD_ERASE, CMD_CONFIRM, '{ARR_ERASE, 3'(6 - i), 1'b0, base[i], 8'h0},
            8'h80);
      for (int i = 0; i < 4; i++)
         op({i[1:0], 16'h0}, CMD_ERASE_UNI, CMD_CONFIRM, '{ARR_ERASE, 3'(i), 1'b1, 18'h0,
            8'h0}, 8'h80);
      top_boot_lock_n = 1'b0;
      op(a, CMD_PROG, 8'h00, NONE, 8'h92);
      op(SEC3_BASE, CMD_ERASE_UNI, CMD_CONFIRM, NONE, 8'ha2);
      op(SEC3_BASE, CMD_ERASE, CMD_CONFIRM, '{ARR_ERASE, 3'h3, 1'b0, 18'h0, 8'h0},
         8'h80);
      {top_boot_lock_n, write_protect_n} = 2'b10;
      op(18'h10000, CMD_ERASE, CMD_CONFIRM, NONE, 8'ha2);
      op(a, CMD_PROG, 8'h5a, '{ARR_PROG, 3'h6, 1'b0, a, 8'h5a}, 8'h80);
      wr(a, CMD_PROG);
      init_n = 1'b0;
      @(negedge sys_clk) init_n = 1'b1;
      wr(a, 8'h00);
      rd(1'b0, a, mem(a));
      a = rnd();
      {reset_pin_n, interface_select} = 2'b01;
      repeat (2) @(negedge sys_clk);
      reset_pin_n = 1'b1;
      @(negedge sys_clk) mux_addr = a[10:0];
      @(negedge sys_clk) clk_pin_row_col = 1'b0;
      @(negedge sys_clk) mux_addr = {4'h0, a[17:11]};
      @(negedge sys_clk) clk_pin_row_col = 1'b1;
      @(negedge sys_clk) init_n = 1'b0;
      repeat (3) @(negedge sys_clk);
      check4(lad_out, mem(a) & 8'h0f);
      check4(mux_data_out, mem(a) >> 4);
      check4({lad_oe, mux_data_oe, 2'h0}, 4'hc);
      if (exp_q.size() || cmd_q.size())
         failures++;
      wrap_up();
   end
endmodule
